/* File: src/vector_map_pkg.sv */
// Constants and types shared by the interrupt vector map and its priority picker.
// Assumes a single 20 MHz core clock and a synchronous active-high chip reset.
package vector_map_pkg;

    localparam int NUM_SRC = 18;
    localparam int IDX_W = 5;
    localparam int ADDR_W = 12;

    // Source indices; a source's vector word is its index plus the first vector word.
    localparam logic [IDX_W-1:0] SRC_EXT_A = 5'h00;
    localparam logic [IDX_W-1:0] SRC_PIN_CHANGE = 5'h01;
    localparam logic [IDX_W-1:0] SRC_FAST_MATCH_A = 5'h02;
    localparam logic [IDX_W-1:0] SRC_BASIC_OVF = 5'h05;
    localparam logic [IDX_W-1:0] SRC_EXT_B = 5'h0C;
    localparam logic [IDX_W-1:0] SRC_BASIC_MATCH_A = 5'h0D;
    localparam logic [IDX_W-1:0] SRC_FAULT = 5'h11;

    localparam logic [ADDR_W-1:0] RESET_VECTOR = 12'h000;
    localparam logic [ADDR_W-1:0] VEC_FIRST = 12'h001;
    localparam logic [ADDR_W-1:0] VEC_EXT_A = 12'h001;
    localparam logic [ADDR_W-1:0] VEC_PIN_CHANGE = 12'h002;
    localparam logic [ADDR_W-1:0] VEC_FAST_MATCH_A = 12'h003;
    localparam logic [ADDR_W-1:0] VEC_FAST_MATCH_B = 12'h004;
    localparam logic [ADDR_W-1:0] VEC_FAST_OVF = 12'h005;
    localparam logic [ADDR_W-1:0] VEC_BASIC_OVF = 12'h006;
    localparam logic [ADDR_W-1:0] VEC_SERIAL_START = 12'h007;
    localparam logic [ADDR_W-1:0] VEC_SERIAL_OVF = 12'h008;
    localparam logic [ADDR_W-1:0] VEC_EEPROM = 12'h009;
    localparam logic [ADDR_W-1:0] VEC_COMPARATOR = 12'h00A;
    localparam logic [ADDR_W-1:0] VEC_CONVERTER = 12'h00B;
    localparam logic [ADDR_W-1:0] VEC_WATCHDOG = 12'h00C;
    localparam logic [ADDR_W-1:0] VEC_EXT_B = 12'h00D;
    localparam logic [ADDR_W-1:0] VEC_BASIC_MATCH_A = 12'h00E;
    localparam logic [ADDR_W-1:0] VEC_BASIC_MATCH_B = 12'h00F;
    localparam logic [ADDR_W-1:0] VEC_CAPTURE = 12'h010;
    localparam logic [ADDR_W-1:0] VEC_FAST_MATCH_D = 12'h011;
    localparam logic [ADDR_W-1:0] VEC_FAULT = 12'h012;

    typedef enum logic [1:0] {
        ST_RESET_VEC = 2'b00,
        ST_IDLE = 2'b01,
        ST_OFFER = 2'b10
    } state_t;

    typedef struct packed {
        state_t state;
        logic vectorValid;
        logic [ADDR_W-1:0] vectorAddr;
        logic [IDX_W-1:0] offeredIdx;
        logic extPinAFlag;
        logic extPinBFlag;
    } ctl_t;

    localparam ctl_t CTL_RESET = '{state: ST_RESET_VEC, vectorValid: 1'b1, vectorAddr: RESET_VECTOR,
                                   offeredIdx: 5'h00, extPinAFlag: 1'b0, extPinBFlag: 1'b0};

endpackage

/* File: src/lowest_request_pick.sv */
// Picks the lowest-numbered active bit of the pending request vector.
// Purely combinational; the caller registers the result.
`timescale 1ns/1ps
module lowest_request_pick
    import vector_map_pkg::*;
(
    input wire logic [NUM_SRC-1:0] pending,
    output logic found,
    output logic [IDX_W-1:0] index
);

    logic [NUM_SRC-1:0] lowerActive;
    logic [NUM_SRC-1:0] isWinner;

    // Each bit wins only when no lower bit is active.
    genvar g;
    generate
        for (g = 0; g < NUM_SRC; g++) begin : g_pick
            if (g == 0) begin : g_first
                assign lowerActive[g] = 1'b0;
            end else begin : g_rest
                assign lowerActive[g] = lowerActive[g-1] | pending[g-1];
            end
            assign isWinner[g] = pending[g] & ~lowerActive[g];
        end
    endgenerate

    always_comb begin
        found = |pending;
        index = 5'h00;
        for (int i = 0; i < NUM_SRC; i++) begin
            if (isWinner[i]) begin
                index = i[IDX_W-1:0];
            end
        end
    end

endmodule

/* File: src/interrupt_vector_map.sv */
// Maps reset and peripheral interrupt requests onto program-memory vector words for the core.
// The core takes an offered vector at an instruction boundary and answers with a one-cycle acknowledge.
`timescale 1ns/1ps
module interrupt_vector_map
    import vector_map_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic ext_pin_irq_a,
    input wire logic pin_change_irq,
    input wire logic fast_timer_match_a_irq,
    input wire logic fast_timer_match_b_irq,
    input wire logic fast_timer_overflow_irq,
    input wire logic basic_timer_overflow_irq,
    input wire logic serial_start_irq,
    input wire logic serial_count_overflow_irq,
    input wire logic eeprom_ready_irq,
    input wire logic comparator_irq,
    input wire logic converter_done_irq,
    input wire logic watchdog_timeout_irq,
    input wire logic ext_pin_irq_b,
    input wire logic basic_timer_match_a_irq,
    input wire logic basic_timer_match_b_irq,
    input wire logic timer_capture_irq,
    input wire logic fast_timer_match_d_irq,
    input wire logic fault_protection_irq,
    input wire logic [NUM_SRC-1:0] sourceEnable,
    input wire logic extPinAFlagClear,
    input wire logic extPinBFlagClear,
    input wire logic coreReady,
    input wire logic vectorAck,
    output logic vectorValid,
    output logic [ADDR_W-1:0] vectorAddr,
    output logic ext_pin_a_flag,
    output logic ext_pin_b_flag
);

    ctl_t ctl;
    ctl_t next_ctl;
    logic [NUM_SRC-1:0] requests;
    logic [NUM_SRC-1:0] pending;
    logic found;
    logic [IDX_W-1:0] winIdx;
    logic launch;
    logic ackTaken;

    // External pins are edge triggers held in flags; every other source is a level held by its peripheral.
    always_comb begin
        requests = {fault_protection_irq, fast_timer_match_d_irq, timer_capture_irq,
                    basic_timer_match_b_irq, basic_timer_match_a_irq, ctl.extPinBFlag,
                    watchdog_timeout_irq, converter_done_irq, comparator_irq, eeprom_ready_irq,
                    serial_count_overflow_irq, serial_start_irq, basic_timer_overflow_irq,
                    fast_timer_overflow_irq, fast_timer_match_b_irq, fast_timer_match_a_irq,
                    pin_change_irq, ctl.extPinAFlag};
        // A source that is not enabled never redirects the core.
        pending = requests & sourceEnable;
    end

    lowest_request_pick u_pick (
        .pending(pending),
        .found(found),
        .index(winIdx)
    );

    assign launch = (ctl.state == ST_IDLE) && coreReady && found;
    assign ackTaken = ctl.vectorValid && vectorAck;

    always_comb begin
        next_ctl = ctl;
        // A trigger in the same cycle as a clear wins over the clear.
        if (ext_pin_irq_a) begin
            next_ctl.extPinAFlag = 1'b1;
        end else if (extPinAFlagClear ||
                     (ackTaken && ctl.state == ST_OFFER && ctl.offeredIdx == SRC_EXT_A)) begin
            next_ctl.extPinAFlag = 1'b0;
        end
        if (ext_pin_irq_b) begin
            next_ctl.extPinBFlag = 1'b1;
        end else if (extPinBFlagClear ||
                     (ackTaken && ctl.state == ST_OFFER && ctl.offeredIdx == SRC_EXT_B)) begin
            next_ctl.extPinBFlag = 1'b0;
        end
        unique case (ctl.state)
            ST_RESET_VEC: begin
                // The reset vector stays offered until the core fetches from it.
                next_ctl.vectorValid = 1'b1;
                next_ctl.vectorAddr = RESET_VECTOR;
                if (vectorAck) begin
                    next_ctl.vectorValid = 1'b0;
                    next_ctl.state = ST_IDLE;
                end
            end
            ST_IDLE: begin
                if (launch) begin
                    next_ctl.vectorValid = 1'b1;
                    next_ctl.offeredIdx = winIdx;
                    // Vector word is the vector number minus one.
                    next_ctl.vectorAddr = VEC_FIRST + {7'h00, winIdx};
                    next_ctl.state = ST_OFFER;
                end
            end
            ST_OFFER: begin
                // Other requests stay pending and are picked again after this one is taken.
                if (vectorAck) begin
                    next_ctl.vectorValid = 1'b0;
                    next_ctl.state = ST_IDLE;
                end
            end
            default: begin
                next_ctl = CTL_RESET;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ctl <= CTL_RESET;
        end else begin
            ctl <= next_ctl;
        end
    end

    assign vectorValid = ctl.vectorValid;
    assign vectorAddr = ctl.vectorAddr;
    assign ext_pin_a_flag = ctl.extPinAFlag;
    assign ext_pin_b_flag = ctl.extPinBFlag;

    reset_vector_a: assert property (@(posedge clk_sys) disable iff (rst)
        $fell(rst) |-> vectorValid && vectorAddr == RESET_VECTOR)
        else $error("Reset did not offer the reset vector.");

    ext_a_vector_a: assert property (@(posedge clk_sys) disable iff (rst)
        launch && pending[SRC_EXT_A] |=> vectorValid && vectorAddr == VEC_EXT_A)
        else $error("First external pin did not vector to its word.");

    pin_change_vec_a: assert property (@(posedge clk_sys) disable iff (rst)
        launch && pending[1:0] == 2'h2 |=> vectorAddr == VEC_PIN_CHANGE)
        else $error("Pin change did not vector to its word.");

    fast_match_vec_a: assert property (@(posedge clk_sys) disable iff (rst)
        launch && pending[2:0] == 3'h4 |=> vectorAddr == VEC_FAST_MATCH_A)
        else $error("Fast timer match A took the wrong word.");

    mid_block_vec_a: assert property (@(posedge clk_sys) disable iff (rst)
        launch && pending[5:0] == 6'h20 |=> vectorAddr == VEC_BASIC_OVF ##1 1'b1)
        else $error("Basic timer overflow took the wrong word.");

    watchdog_vec_a: assert property (@(posedge clk_sys) disable iff (rst)
        launch && pending[11:0] == 12'h800 |=> vectorAddr == VEC_WATCHDOG)
        else $error("Watchdog timeout took the wrong word.");

    ext_b_vector_a: assert property (@(posedge clk_sys) disable iff (rst)
        launch && pending[12:0] == 13'h1000 |=> vectorAddr == VEC_EXT_B)
        else $error("Second external pin did not vector to its word.");

    basic_match_vec_a: assert property (@(posedge clk_sys) disable iff (rst)
        launch && pending[13:0] == 14'h2000 |=> vectorAddr == VEC_BASIC_MATCH_A)
        else $error("Basic timer match A took the wrong word.");

    fault_vector_a: assert property (@(posedge clk_sys) disable iff (rst)
        launch && pending == 18'h20000 |=> vectorAddr == VEC_FAULT)
        else $error("Fault protection took the wrong word.");

    no_enable_idle_a: assert property (@(posedge clk_sys) disable iff (rst)
        ctl.state == ST_IDLE && pending == 18'h00000 |=> !vectorValid)
        else $error("Vector offered with no enabled source.");

    ext_flag_clear_a: assert property (@(posedge clk_sys) disable iff (rst)
        ctl.state == ST_OFFER && vectorAck && ctl.offeredIdx == SRC_EXT_A && !ext_pin_irq_a
        |=> !ext_pin_a_flag)
        else $error("Serviced external flag was not cleared.");

    flag_set_wins_a: assert property (@(posedge clk_sys) disable iff (rst)
        ext_pin_irq_b |=> ext_pin_b_flag)
        else $error("External trigger lost against a clear.");

    offer_held_a: assert property (@(posedge clk_sys) disable iff (rst)
        ctl.state == ST_OFFER && !vectorAck |=> vectorValid && $stable(vectorAddr))
        else $error("Offered vector changed before it was taken.");

    addr_from_number_a: assert property (@(posedge clk_sys) disable iff (rst)
        launch |=> vectorAddr >= VEC_FIRST && vectorAddr <= VEC_FAULT &&
            (($past(pending) >> (vectorAddr - VEC_FIRST)) & 18'h00001) == 18'h00001)
        else $error("Vector word is not vector number minus one.");

    lowest_first_a: assert property (@(posedge clk_sys) disable iff (rst)
        launch |=> (18'h00001 << (vectorAddr - VEC_FIRST)) == ($past(pending) & (~$past(pending) + 18'h00001)))
        else $error("Offered vector is not the lowest pending one.");

    ack_drops_offer_a: assert property (@(posedge clk_sys) disable iff (rst)
        ctl.state == ST_OFFER && vectorAck |=> !vectorValid)
        else $error("Offer stood after it was taken.");

    reset_offer_held_a: assert property (@(posedge clk_sys) disable iff (rst)
        ctl.state == ST_RESET_VEC && !vectorAck |=> vectorValid && vectorAddr == RESET_VECTOR)
        else $error("Reset vector offer dropped before it was taken.");

    fast_match_b_a: assert property (@(posedge clk_sys) disable iff (rst)
        launch && pending[3:0] == 4'h8 |=> vectorAddr == VEC_FAST_MATCH_B)
        else $error("Fast timer match B took the wrong word.");

    fast_overflow_vec_a: assert property (@(posedge clk_sys) disable iff (rst)
        launch && pending[4:0] == 5'h10 |=> vectorAddr == VEC_FAST_OVF)
        else $error("Fast timer overflow took the wrong word.");

    serial_start_vec_a: assert property (@(posedge clk_sys) disable iff (rst)
        launch && pending[6:0] == 7'h40 |=> vectorAddr == VEC_SERIAL_START)
        else $error("Serial start took the wrong word.");

    serial_ovf_vec_a: assert property (@(posedge clk_sys) disable iff (rst)
        launch && pending[7:0] == 8'h80 |=> vectorAddr == VEC_SERIAL_OVF)
        else $error("Serial counter overflow took the wrong word.");

    eeprom_vec_a: assert property (@(posedge clk_sys) disable iff (rst)
        launch && pending[8:0] == 9'h100 |=> vectorAddr == VEC_EEPROM)
        else $error("EEPROM ready took the wrong word.");

    comparator_vec_a: assert property (@(posedge clk_sys) disable iff (rst)
        launch && pending[9:0] == 10'h200 |=> vectorAddr == VEC_COMPARATOR)
        else $error("Comparator took the wrong word.");

    converter_vec_a: assert property (@(posedge clk_sys) disable iff (rst)
        launch && pending[10:0] == 11'h400 |=> vectorAddr == VEC_CONVERTER)
        else $error("Converter complete took the wrong word.");

    basic_match_b_a: assert property (@(posedge clk_sys) disable iff (rst)
        launch && pending[14:0] == 15'h4000 |=> vectorAddr == VEC_BASIC_MATCH_B)
        else $error("Basic timer match B took the wrong word.");

    capture_vec_a: assert property (@(posedge clk_sys) disable iff (rst)
        launch && pending[15:0] == 16'h8000 |=> vectorAddr == VEC_CAPTURE)
        else $error("Timer capture took the wrong word.");

    fast_match_d_a: assert property (@(posedge clk_sys) disable iff (rst)
        launch && pending[16:0] == 17'h10000 |=> vectorAddr == VEC_FAST_MATCH_D)
        else $error("Fast timer match D took the wrong word.");

    ext_b_clear_a: assert property (@(posedge clk_sys) disable iff (rst)
        ctl.state == ST_OFFER && vectorAck && ctl.offeredIdx == SRC_EXT_B && !ext_pin_irq_b
        |=> !ext_pin_b_flag)
        else $error("Serviced second external flag was not cleared.");

endmodule

/* File: verif/core_model.sv */
// Behavioural model of the core's vector fetch side of the interrupt vector map.
// Assumes the map's one-cycle acknowledge handshake on clk_sys and a synchronous active-high reset.
`timescale 1ns/1ps
module core_model
    import vector_map_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic vectorValid,
    input wire logic [ADDR_W-1:0] vectorAddr,
    input wire logic readyIn,
    input wire logic [3:0] ackDelay,
    output logic coreReady,
    output logic vectorAck,
    output logic [ADDR_W-1:0] takenAddr,
    output logic [7:0] takenCount
);
    logic [3:0] waited;
    assign coreReady = readyIn;
    // An offer is taken after ackDelay idle cycles, so both prompt and slow cores are modelled.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            vectorAck <= 1'b0;
            waited <= 4'h0;
            takenAddr <= 12'hFFF;
            takenCount <= 8'h00;
        end else if (vectorValid && !vectorAck) begin
            if (waited == ackDelay) begin
                vectorAck <= 1'b1;
                takenAddr <= vectorAddr;
                takenCount <= takenCount + 8'h01;
                waited <= 4'h0;
            end else begin
                waited <= waited + 4'h1;
            end
        end else begin
            vectorAck <= 1'b0;
        end
    end
endmodule

/* File: verif/tb_top.sv */
// Self-checking bench for the interrupt vector map with a behavioural core on its far side.
// Assumes a 20 MHz clk_sys; the bench plays every peripheral and drops a level request once it is taken.
`timescale 1ns/1ps
module tb_top;
    import vector_map_pkg::*;
    logic clk_sys, rst, readyIn, flagClearA, flagClearB, coreReady, vectorAck, vectorValid, flagA, flagB;
    logic [17:0] req, en;
    logic [3:0] ackDelay;
    logic [11:0] vectorAddr, takenAddr;
    logic [7:0] takenCount, cnt;
    int n_errors = 0, samples_checked = 0;
    localparam logic [11:0] VEC_TAB [18] = '{12'h001, 12'h002, 12'h003, 12'h004, 12'h005, 12'h006, 12'h007,
        12'h008, 12'h009, 12'h00A, 12'h00B, 12'h00C, 12'h00D, 12'h00E, 12'h00F, 12'h010, 12'h011, 12'h012};

    interrupt_vector_map interrupt_vector_map_i (.clk_sys(clk_sys), .rst(rst),
        .ext_pin_irq_a(req[0]), .pin_change_irq(req[1]), .fast_timer_match_a_irq(req[2]),
        .fast_timer_match_b_irq(req[3]), .fast_timer_overflow_irq(req[4]), .basic_timer_overflow_irq(req[5]),
        .serial_start_irq(req[6]), .serial_count_overflow_irq(req[7]), .eeprom_ready_irq(req[8]),
        .comparator_irq(req[9]), .converter_done_irq(req[10]), .watchdog_timeout_irq(req[11]),
        .ext_pin_irq_b(req[12]), .basic_timer_match_a_irq(req[13]), .basic_timer_match_b_irq(req[14]),
        .timer_capture_irq(req[15]), .fast_timer_match_d_irq(req[16]), .fault_protection_irq(req[17]),
        .sourceEnable(en), .extPinAFlagClear(flagClearA), .extPinBFlagClear(flagClearB),
        .coreReady(coreReady), .vectorAck(vectorAck), .vectorValid(vectorValid), .vectorAddr(vectorAddr),
        .ext_pin_a_flag(flagA), .ext_pin_b_flag(flagB));
    core_model core_model_i (.clk_sys(clk_sys), .rst(rst), .vectorValid(vectorValid), .vectorAddr(vectorAddr),
        .readyIn(readyIn), .ackDelay(ackDelay), .coreReady(coreReady), .vectorAck(vectorAck),
        .takenAddr(takenAddr), .takenCount(takenCount));

    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #2;
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wait_taken(input logic [7:0] n);
        int k;
        for (k = 0; k < 60 && takenCount !== n; k++) tick(1);
        check(takenCount, n);
    endtask
    task automatic tally_and_finish;
        $display("errors=%0d checks=%0d", n_errors, samples_checked);
        if (n_errors == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    initial begin
        repeat (5000) @(posedge clk_sys);
        n_errors++;
        tally_and_finish();
    end

    initial begin
        rst = 1'b1;
        req = '0;
        en = '0;
        flagClearA = 1'b0;
        flagClearB = 1'b0;
        readyIn = 1'b1;
        ackDelay = 4'h0;
        tick(10);
        rst = 1'b0;
        wait_taken(8'h01);
        check(takenAddr, 12'h000);
        en = '1;
        // One source at a time; the external pins only pulse, the rest hold until taken.
        for (int i = 0; i < 18; i++) begin
            req[i] = 1'b1;
            tick(1);
            if (i == 0 || i == 12) req[i] = 1'b0;
            wait_taken(8'(i + 2));
            check(takenAddr, VEC_TAB[i]);
            req = '0;
            tick(3);
            check({flagA, flagB}, 2'b00);
        end
        cnt = takenCount;
        // Three requests wait behind a stalled core, then come out lowest vector first.
        readyIn = 1'b0;
        ackDelay = 4'h3;
        req = 18'h20024;
        tick(6);
        check(vectorValid, 1'b0);
        readyIn = 1'b1;
        wait_taken(cnt + 8'h01);
        check(takenAddr, 12'h003);
        req[2] = 1'b0;
        wait_taken(cnt + 8'h02);
        check(takenAddr, 12'h006);
        req[5] = 1'b0;
        wait_taken(cnt + 8'h03);
        check(takenAddr, 12'h012);
        req = '0;
        tick(4);
        en = '0;
        req = 18'h3EFFE;
        tick(20);
        check({vectorValid, takenCount}, {1'b0, cnt + 8'h03});
        req = '0;
        req[0] = 1'b1;
        req[12] = 1'b1;
        tick(1);
        req = '0;
        tick(1);
        check({flagA, flagB}, 2'b11);
        flagClearA = 1'b1;
        flagClearB = 1'b1;
        tick(1);
        check({flagA, flagB}, 2'b00);
        req[0] = 1'b1;
        req[12] = 1'b1;
        tick(1);
        flagClearA = 1'b0;
        flagClearB = 1'b0;
        req = '0;
        tick(1);
        check({flagA, flagB}, 2'b11);
        en = 18'h00001;
        wait_taken(cnt + 8'h04);
        check(takenAddr, 12'h001);
        tick(3);
        check({flagA, flagB}, 2'b01);
        rst = 1'b1;
        tick(1);
        check({vectorValid, vectorAddr, flagA, flagB}, {1'b1, 12'h000, 2'b00});
        tick(2);
        rst = 1'b0;
        wait_taken(8'h01);
        check(takenAddr, 12'h000);
        tally_and_finish();
    end
endmodule
